// ===== shared/reset_manager_pkg.sv
// constants and types shared by the reset manager design
package reset_manager_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] cause_flags_offset  = 8'h00;
  localparam logic [7:0] soft_reset_offset   = 8'h01;
  localparam logic [7:0] guard_unlock_offset = 8'h02;
  localparam logic [7:0] io_register_key     = 8'hd8;
  localparam logic [7:0] soft_reset_reset    = 8'h00;

  // ----------------------------------------------------------------
  // field positions in reset_cause_flags, and the trigger bit of the soft reset register
  // ----------------------------------------------------------------
  localparam int power_on_bit   = 0;
  localparam int brownout_bit   = 1;
  localparam int pin_bit        = 2;
  localparam int watchdog_bit   = 3;
  localparam int software_bit   = 4;
  localparam int debug_port_bit = 5;
  localparam int flag_count     = 6;
  localparam int trigger_bit    = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int clock_period_ns     = 40;
  localparam int source_pulse_ns     = 50;
  localparam int source_pulse_cycles = (source_pulse_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int unlock_window_cycles = 4;
  localparam int fuse_load_cycles    = 8;
  localparam int startup_unit_cycles = 64;
  localparam int init_count_width    = 12;
  localparam int pulse_count_width   = 2;
  localparam int unlock_count_width  = 3;

  typedef enum logic [3:0] {
    st_hold  = 4'b0001,
    st_fuse  = 4'b0010,
    st_delay = 4'b0100,
    st_run   = 4'b1000
  } seq_state_t;

endpackage

// ===== rtl/pulse_stretcher.sv
// stretches a one-cycle reset trigger into a pulse of fixed length
`timescale 1ns/1ns
module pulse_stretcher
  import reset_manager_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      pulse
);

  logic [pulse_count_width-1:0] remain;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
    end else if (trigger) begin
      remain <= pulse_count_width'(source_pulse_cycles);
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign pulse = (remain != '0);

endmodule

// ===== rtl/unlock_guard.sv
// configuration-change guard: key opens a short write window
`timescale 1ns/1ns
module unlock_guard
  import reset_manager_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       key_write,
  input  wire logic [7:0] key_data,
  input  wire logic       protected_write,
  output logic            unlocked
);

  logic [unlock_count_width-1:0] window;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      window <= '0;
    end else if (key_write && key_data == io_register_key) begin
      window <= unlock_count_width'(unlock_window_cycles);
    end else if (protected_write) begin
      // one protected write consumes the window
      window <= '0;
    end else if (window != '0) begin
      window <= window - 1'b1;
    end
  end

  assign unlocked = (window != '0);

endmodule

// ===== rtl/system_reset_manager.sv
// central reset manager: source merge, init sequence, cause flags
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns

module system_reset_manager
  import reset_manager_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       power_on_request,
  input  wire logic       brownout_request,
  input  wire logic       reset_pin_n,
  input  wire logic       reset_pin_config,
  input  wire logic       watchdog_timeout,
  input  wire logic       debug_port_request,
  input  wire logic [2:0] startup_delay_select,
  input  wire logic       scan_source_select,
  input  wire logic       boot_memory_scan_done,
  output logic            device_reset,
  output logic            debug_port_reset,
  output logic            fuse_reload,
  output logic            boot_memory_scan_start,
  output logic            boot_complete
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire hit_flags   = (reg_addr == cause_flags_offset);
  wire hit_soft    = (reg_addr == soft_reset_offset);
  wire hit_guard   = (reg_addr == guard_unlock_offset);
  wire write_flags = reg_write && hit_flags;
  wire write_soft  = reg_write && hit_soft;
  wire key_write   = reg_write && hit_guard;
  wire unlocked;

  unlock_guard guard_u (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .key_write       (key_write),
    .key_data        (reg_wdata),
    .protected_write (write_soft),
    .unlocked        (unlocked)
  );

  wire soft_trigger = write_soft && unlocked && reg_wdata[trigger_bit];

  // ----------------------------------------------------------------
  // source pulses
  // ----------------------------------------------------------------
  logic watchdog_pulse;
  logic software_pulse;

  pulse_stretcher watchdog_u (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .trigger (watchdog_timeout),
    .pulse   (watchdog_pulse)
  );

  pulse_stretcher software_u (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .trigger (soft_trigger),
    .pulse   (software_pulse)
  );

  // ----------------------------------------------------------------
  // source merge
  // ----------------------------------------------------------------
  // pin gated by fuse
  wire pin_request    = reset_pin_config && !reset_pin_n;
  wire supply_request = power_on_request || brownout_request;
  wire [flag_count-1:0] source_vec;
  assign source_vec[power_on_bit]   = power_on_request;
  assign source_vec[brownout_bit]   = brownout_request;
  assign source_vec[pin_bit]        = pin_request;
  assign source_vec[watchdog_bit]   = watchdog_pulse || watchdog_timeout;
  assign source_vec[software_bit]   = software_pulse || soft_trigger;
  assign source_vec[debug_port_bit] = debug_port_request;
  wire any_source = |source_vec;

  // ----------------------------------------------------------------
  // initialization sequence
  // ----------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  logic [init_count_width-1:0] count;
  logic [init_count_width-1:0] next_count;
  logic supply_seen;
  logic scan_running;

  wire [init_count_width-1:0] startup_cycles =
    init_count_width'(({9'h000, startup_delay_select}) * startup_unit_cycles);
  wire count_zero = (count == '0);
  wire scan_busy  = scan_source_select && !boot_memory_scan_done;

  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      st_hold: begin
        if (!any_source) begin
          next_state = st_fuse;
          next_count = init_count_width'(fuse_load_cycles);
        end
      end
      st_fuse: begin
        if (count_zero) begin
          next_state = st_delay;
          next_count = supply_seen ? startup_cycles : '0;
        end else begin
          next_count = count - 1'b1;
        end
      end
      st_delay: begin
        if (!count_zero) begin
          next_count = count - 1'b1;
        end else if (!scan_busy) begin
          next_state = st_run;
        end
      end
      st_run: begin
        next_state = st_run;
      end
      default: begin
        next_state = st_hold;
      end
    endcase
    if (any_source) begin
      next_state = st_hold;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_hold;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // supply cause stays known until the sequence ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supply_seen <= 1'b1;
    end else if (supply_request) begin
      supply_seen <= 1'b1;
    end else if (state == st_run) begin
      supply_seen <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scan_running <= 1'b0;
    end else begin
      scan_running <= (next_state == st_delay) && scan_source_select;
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  logic [flag_count-1:0] cause_flags;
  logic                  boot_done;
  wire [flag_count-1:0] set_mask =
    boot_done ? source_vec : (source_vec & flag_count'(1 << power_on_bit));
  wire [flag_count-1:0] clear_mask = write_flags ? reg_wdata[flag_count-1:0] : '0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cause_flags <= flag_count'(1 << power_on_bit);
    end else if (power_on_request) begin
      cause_flags <= flag_count'(1 << power_on_bit);
    end else begin
      // record source; set wins over clear
      cause_flags <= (cause_flags & ~clear_mask) | set_mask;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_done <= 1'b0;
    end else if (power_on_request) begin
      boot_done <= 1'b0;
    end else if (state == st_run) begin
      boot_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // register map
  wire [7:0] read_mux = hit_flags ? {2'b00, cause_flags} : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? read_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      device_reset           <= 1'b1;
      debug_port_reset       <= 1'b1;
      fuse_reload            <= 1'b0;
      boot_memory_scan_start <= 1'b0;
      boot_complete          <= 1'b0;
    end else begin
      device_reset           <= (next_state != st_run);
      debug_port_reset       <= supply_request;
      fuse_reload            <= (next_state == st_fuse);
      boot_memory_scan_start <= scan_running;
      boot_complete          <= (next_state == st_run);
    end
  end

endmodule

// ===== testbench/far_side_model.sv
// far-side model: boot memory scan engine and external debugger
`timescale 1ns/1ns
module far_side_model #(
  parameter int scan_cycles = 20
) (
  input  wire logic mclk,
  input  wire logic scan_start,
  output logic      scan_done,
  output logic      debug_req
);
  int scan_count;

  initial begin
    debug_req = 1'b0;
  end

  always @(posedge mclk) begin
    scan_count <= scan_start ? scan_count + 1 : 0;
  end
  // done drops with start, like a released line
  assign scan_done = scan_start && (scan_count >= scan_cycles);

  task automatic debugger_reset(input int cycles);
    @(posedge mclk);
    debug_req <= 1'b1;
    repeat (cycles) @(posedge mclk);
    debug_req <= 1'b0;
  endtask
endmodule

// ===== testbench/reset_manager_sva.sv
// port assertions for the reset manager
`timescale 1ns/1ns
module reset_manager_sva
  import reset_manager_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       power_on_request,
  input wire logic       brownout_request,
  input wire logic       reset_pin_n,
  input wire logic       reset_pin_config,
  input wire logic       watchdog_timeout,
  input wire logic       debug_port_request,
  input wire logic       boot_memory_scan_start,
  input wire logic       boot_memory_scan_done,
  input wire logic       device_reset,
  input wire logic       debug_port_reset,
  input wire logic       fuse_reload,
  input wire logic       boot_complete
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_supply_hold: assert property ((power_on_request || brownout_request) |=> device_reset && debug_port_reset)
    else $error("supply request not holding reset");
  chk_pin_hold: assert property ((reset_pin_config && !reset_pin_n) || debug_port_request |=> device_reset)
    else $error("user request not holding reset");
  // the attempt at the release edge already sees the output cleared one cycle later, as the flop leaves reset on that same edge
  chk_user_debug: assert property (rst_n && !power_on_request && !brownout_request |=> !debug_port_reset)
    else $error("debug port reset without supply request");
  chk_watchdog_reset: assert property ($rose(watchdog_timeout) |=> device_reset)
    else $error("watchdog timeout ignored");
  chk_soft_trigger: assert property (reg_write && reg_addr == soft_reset_offset && reg_wdata[trigger_bit] &&
    $past(reg_write) && $past(reg_addr) == guard_unlock_offset && $past(reg_wdata) == io_register_key
    |=> ##[0:1] device_reset) else $error("unlocked trigger ignored");
  chk_trigger_zero: assert property (reg_read && reg_addr == soft_reset_offset |=> reg_rdata == 8'h00)
    else $error("trigger read not zero");
  chk_fuse_phase: assert property ($rose(fuse_reload) |-> (fuse_reload && device_reset)[*8])
    else $error("fuse load phase short");
  chk_scan_wait: assert property (boot_memory_scan_start && !boot_memory_scan_done |=> device_reset)
    else $error("released before scan done");
  chk_boot_inverse: assert property (boot_complete != device_reset)
    else $error("boot flag disagrees with reset");
  chk_release_quiet: assert property ($fell(device_reset) |-> !$past(power_on_request) && !$past(debug_port_request))
    else $error("released while source active");
endmodule

bind system_reset_manager reset_manager_sva chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .power_on_request, .brownout_request, .reset_pin_n, .reset_pin_config, .watchdog_timeout,
  .debug_port_request, .boot_memory_scan_start, .boot_memory_scan_done, .device_reset, .debug_port_reset,
  .fuse_reload, .boot_complete);

// ===== testbench/testbench.sv
// self-checking bench for the reset manager
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module testbench
  import reset_manager_pkg::*;
;
  logic       mclk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic       power_on_request = 1'b0, brownout_request = 1'b0, reset_pin_n = 1'b1;
  logic       reset_pin_config = 1'b1, watchdog_timeout = 1'b0, scan_source_select = 1'b1;
  logic [2:0] startup_delay_select = 3'h1;
  logic       debug_port_request, boot_memory_scan_done, boot_memory_scan_start;
  logic       device_reset, debug_port_reset, fuse_reload, boot_complete;
  int         err_count = 0, checks_done = 0, n;

  initial forever #20 mclk = ~mclk;

  system_reset_manager uut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .power_on_request, .brownout_request, .reset_pin_n, .reset_pin_config, .watchdog_timeout,
    .debug_port_request, .startup_delay_select, .scan_source_select, .boot_memory_scan_done,
    .device_reset, .debug_port_reset, .fuse_reload, .boot_memory_scan_start, .boot_complete);
  far_side_model far (.mclk, .scan_start(boot_memory_scan_start), .scan_done(boot_memory_scan_done),
    .debug_req(debug_port_request));

  // ----------------------------------------------------------------
  // bus and wait helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  // one-cycle write strobe, lowered at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic wr_guarded(input logic [7:0] v);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr  <= guard_unlock_offset;
    reg_wdata <= io_register_key;
    @(posedge mclk);
    reg_addr  <= soft_reset_offset;
    reg_wdata <= v;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    reg_addr  <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_for(input bit boot, input int lim);
    n = 0;
    while ((boot ? boot_complete : device_reset) !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= lim) begin
      err_count++;
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_on();
    @(posedge mclk);
    power_on_request <= 1'b1;
    reset_pin_n <= 1'b0;
    tick(5);
    @(posedge mclk);
    power_on_request <= 1'b0;
    tick(5);
    `CHK(device_reset, 1'b1)
    @(posedge mclk);
    reset_pin_n <= 1'b1;
    wait_for(1, 2000);
    rd(cause_flags_offset);
    `CHK(d, 8'h01)
    rd(soft_reset_offset);
    `CHK(d, 8'h00)
    $display("power-on test done");
  endtask

  task automatic t_soft();
    wr(guard_unlock_offset, io_register_key);
    tick(5);
    wr(soft_reset_offset, 8'h01);
    tick(6);
    `CHK(device_reset, 1'b0)
    wr_guarded(8'h01);
    wait_for(0, 4);
    wait_for(1, 2000);
    rd(cause_flags_offset);
    `CHK(d, 8'h11)
    wr(cause_flags_offset, 8'hff);
    rd(cause_flags_offset);
    `CHK(d, 8'h00)
    $display("software reset test done");
  endtask

  task automatic t_user_sources();
    logic [7:0] expect_flags [4] = '{8'h04, 8'h08, 8'h20, 8'h02};
    @(posedge mclk);
    reset_pin_config <= 1'b0;
    reset_pin_n <= 1'b0;
    tick(4);
    `CHK(device_reset, 1'b0)
    @(posedge mclk);
    reset_pin_n <= 1'b1;
    reset_pin_config <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      case (i)
        0: reset_pin_n <= 1'b0;
        1: watchdog_timeout <= 1'b1;
        2: far.debugger_reset(3);
        default: brownout_request <= 1'b1;
      endcase
      @(posedge mclk);
      watchdog_timeout <= 1'b0;
      tick(2);
      `CHK(device_reset, 1'b1)
      `CHK(debug_port_reset, i == 3)
      @(posedge mclk);
      reset_pin_n <= 1'b1;
      brownout_request <= 1'b0;
      wait_for(1, 2000);
      `CHK(n >= startup_unit_cycles, i == 3)
      rd(cause_flags_offset);
      `CHK(d, expect_flags[i])
      wr(cause_flags_offset, 8'hff);
    end
    rd(8'h05);
    `CHK(d, 8'h00)
    $display("user source test done");
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    wait_for(1, 2000);
    rd(cause_flags_offset);
    `CHK(d, 8'h01)
    t_power_on();
    t_soft();
    t_user_sources();
    end_sim();
  end
endmodule
